// ---- fram_link_pkg.sv ----
// Shared constants and types for the two-wire memory slave.
package fram_link_pkg;

  // Array geometry.
  localparam int unsigned ADDR_W    = 11;
  localparam int unsigned PAGE_W    = 3;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned MEM_DEPTH = 2048;

  // Fields of the slave address byte.
  localparam int unsigned TYPE_MSB = 7;
  localparam int unsigned TYPE_LSB = 4;
  localparam int unsigned PAGE_MSB = 3;
  localparam int unsigned PAGE_LSB = 1;
  localparam int unsigned DIR_BIT  = 0;
  localparam logic        DIR_READ = 1'b1;

  // Bit counter: value after the last data bit, which is the acknowledge slot.
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_NONE  = 4'h0;

  // Values after reset.
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [PAGE_W-1:0] PAGE_RST = 3'h0;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  // Phase of the serial transfer.
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_SLAVE = 3'b001,
    PH_WADDR = 3'b010,
    PH_WDATA = 3'b011,
    PH_RDATA = 3'b100
  } phase_t;

endpackage : fram_link_pkg

// ---- fram_link_slave.sv ----
// Two-wire serial slave with a 2048-byte memory array behind it.
`timescale 1ns/1ps
// Overview of operation
// [R1] Rising data while clock high is STOP; it aborts the current operation.
// [R2] Falling data while clock high is START; recognised at any time.
// [R3] START aborts and returns to waiting for a fresh slave address byte.
// [R4] Data is stable while clock high; bits are sampled during clock high.
// [R5] After eight bits the transmitter releases data; receiver pulls low to acknowledge.
// [R6] A missing acknowledge ends the operation so the device can be readdressed.
// [R7] Upper four slave address bits must equal the device type code.
// [R8] Slave address bits three to one pick the page; bit zero set means read.
// [R9] Write: next byte is low address, joined with page into an eleven-bit address.
// [R10] Read: page from slave address, low eight bits from the address latch.
// [R11] Address increments after each data byte before acknowledge and wraps to zero.
// [R12] No limit on consecutive bytes within one operation.
// [R13] Read: drive eight bits, sample master acknowledge, continue or release.
// [R14] All bytes travel most significant bit first.
// [R15] Write data is stored after its eighth bit; earlier START or STOP stores nothing.
// [R16] Slave address is acknowledged right after a write; no busy state exists.
// [R17] Write protect high: data bytes not acknowledged, address not incremented.
// [R18] Write protect low permits writes to every address.
// [R19] After a read address byte, data leaves from the current address next clock.
// [R20] Master ends a read by no-acknowledge then STOP or START, or STOP or START.
// [R21] Random read: write address byte, repeated START, then read address.
// [R22] The master makes the serial clock; this block is a slave only.
// [R23] Data is shifted out on clock fall and captured on clock rise.
// [R24] The data output is released except for acknowledge or read data bits.
module fram_link_slave #(
  parameter logic [3:0] DEV_TYPE = 4'h6  // Arbitrary value.
) (
  // System clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Serial link
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // Write protect pin
  input  wire logic wp,
  // Status
  output logic      link_busy
);

  localparam int unsigned AW = fram_link_pkg::ADDR_W;
  localparam int unsigned BW = fram_link_pkg::BYTE_W;

  // State on the system clock.
  typedef struct packed {
    logic link_rst;
    logic busy_meta;
    logic busy_sync;
  } sys_t;

  // State captured on the rising serial clock.
  typedef struct packed {
    fram_link_pkg::phase_t state;
    logic [3:0]            cnt;
    logic [BW-1:0]         sh;
    logic [BW-1:0]         rd_sh;
    logic [AW-1:0]         addr;
    logic [fram_link_pkg::PAGE_W-1:0] page;
    logic                  dir_rd;
    logic                  refused;
    logic                  drv;
    logic                  start_seen;
    logic                  stop_seen;
    logic                  wp_meta;
    logic                  wp_sync;
  } rise_t;

  sys_t          s_ff;
  sys_t          nxt_s;
  rise_t         r_ff;
  rise_t         nxt_r;
  logic          fall_drv_ff;
  logic          start_tog_ff;
  logic          stop_tog_ff;
  logic [BW-1:0] mem [fram_link_pkg::MEM_DEPTH];

  logic          start_pend;
  logic          stop_pend;
  logic [AW-1:0] rd_addr;
  logic [BW-1:0] rd_data;
  logic [BW-1:0] in_byte;
  logic          mem_we;
  logic [AW-1:0] mem_wa;
  logic [BW-1:0] mem_wd;

  function automatic logic [AW-1:0] addr_inc(input logic [AW-1:0] a);
    addr_inc = AW'(a + 1'b1);  // [R11]
  endfunction : addr_inc

  // The link reset is a register, so it is free of glitches. It clears the serial
  // logic without a clock because the serial clock may stand still during reset.
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.link_rst  = srst;
    // A STOP shows on the status at once: the serial state only moves at the next
    // clock rise, and the master may leave the clock standing high until then.
    nxt_s.busy_meta = start_pend | ((r_ff.state != fram_link_pkg::PH_IDLE) & ~stop_pend);  // [R1] [R3]
    nxt_s.busy_sync = s_ff.busy_meta;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_ff <= '{link_rst: 1'b1, busy_meta: 1'b0, busy_sync: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link_busy = s_ff.busy_sync;

  // START and STOP are the only data edges while the clock is high. Each flips a
  // toggle; the rising-edge logic compares it with its own copy. The toggle flips
  // while the clock is high and a whole low phase passes before the next rise.
  always_ff @(negedge sda_i or posedge s_ff.link_rst) begin
    if (s_ff.link_rst) begin
      start_tog_ff <= 1'b0;
    end else if (scl) begin
      start_tog_ff <= ~start_tog_ff;  // [R2]
    end
  end

  always_ff @(posedge sda_i or posedge s_ff.link_rst) begin
    if (s_ff.link_rst) begin
      stop_tog_ff <= 1'b0;
    end else if (scl) begin
      stop_tog_ff <= ~stop_tog_ff;  // [R1]
    end
  end

  assign start_pend = start_tog_ff ^ r_ff.start_seen;
  assign stop_pend  = stop_tog_ff ^ r_ff.stop_seen;

  // Read source: the current address is the latched page with the low eight bits
  // of the address latch when the slave address has just been taken.
  always_comb begin
    if (r_ff.state == fram_link_pkg::PH_SLAVE) begin
      rd_addr = {r_ff.page, r_ff.addr[BW-1:0]};  // [R10]
    end else begin
      rd_addr = r_ff.addr;
    end
  end

  assign rd_data = mem[rd_addr];
  assign in_byte = {r_ff.sh[BW-2:0], sda_i};  // [R14]

  always_comb begin
    nxt_r         = r_ff;
    mem_we        = 1'b0;
    mem_wa        = r_ff.addr;
    mem_wd        = in_byte;
    nxt_r.wp_meta = wp;
    nxt_r.wp_sync = r_ff.wp_meta;
    if (start_pend) begin
      // First address bit is captured on this same rise.
      nxt_r.start_seen = start_tog_ff;
      nxt_r.stop_seen  = stop_tog_ff;
      nxt_r.state      = fram_link_pkg::PH_SLAVE;  // [R3]
      nxt_r.cnt        = fram_link_pkg::BIT_FIRST;
      nxt_r.sh         = {{(BW-1){1'b0}}, sda_i};
      nxt_r.refused    = 1'b0;
      nxt_r.drv        = 1'b0;
    end else if (stop_pend) begin
      nxt_r.stop_seen = stop_tog_ff;
      nxt_r.state     = fram_link_pkg::PH_IDLE;  // [R1]
      nxt_r.cnt       = fram_link_pkg::BIT_NONE;
      nxt_r.drv       = 1'b0;
    end else begin
      case (r_ff.state)
        fram_link_pkg::PH_SLAVE,
        fram_link_pkg::PH_WADDR,
        fram_link_pkg::PH_WDATA: begin
          if (r_ff.cnt == fram_link_pkg::BIT_ACK) begin
            // Acknowledge slot is over; the line goes back to the master except after a read slave address.
            nxt_r.drv = 1'b0;  // [R24]
            nxt_r.cnt = fram_link_pkg::BIT_NONE;
            if (r_ff.state == fram_link_pkg::PH_SLAVE) begin
              if (r_ff.dir_rd) begin
                nxt_r.state = fram_link_pkg::PH_RDATA;  // [R19]
                nxt_r.addr  = rd_addr;
                nxt_r.rd_sh = rd_data;
                nxt_r.drv   = ~rd_data[BW-1];  // [R23]
              end else begin
                nxt_r.state = fram_link_pkg::PH_WADDR;
              end
            end else if (r_ff.state == fram_link_pkg::PH_WADDR) begin
              nxt_r.state = fram_link_pkg::PH_WDATA;
            end else if (r_ff.refused) begin
              nxt_r.state = fram_link_pkg::PH_IDLE;  // [R6]
            end
          end else begin
            nxt_r.sh  = in_byte;  // [R4]
            nxt_r.cnt = 4'(r_ff.cnt + 1'b1);
            if (nxt_r.cnt == fram_link_pkg::BIT_ACK) begin
              if (r_ff.state == fram_link_pkg::PH_SLAVE) begin
                if (in_byte[fram_link_pkg::TYPE_MSB:fram_link_pkg::TYPE_LSB] == DEV_TYPE) begin  // [R7]
                  nxt_r.page   = in_byte[fram_link_pkg::PAGE_MSB:fram_link_pkg::PAGE_LSB];  // [R8]
                  nxt_r.dir_rd = (in_byte[fram_link_pkg::DIR_BIT] == fram_link_pkg::DIR_READ);  // [R8]
                  nxt_r.drv    = 1'b1;  // [R16]
                end else begin
                  nxt_r.state = fram_link_pkg::PH_IDLE;
                  nxt_r.cnt   = fram_link_pkg::BIT_NONE;
                end
              end else if (r_ff.state == fram_link_pkg::PH_WADDR) begin
                nxt_r.addr = {r_ff.page, in_byte};  // [R9]
                nxt_r.drv  = 1'b1;  // [R5]
              end else if (r_ff.wp_sync) begin
                // Protected: no store, no acknowledge, address held.
                nxt_r.refused = 1'b1;  // [R17]
                nxt_r.drv     = 1'b0;  // [R17]
              end else begin
                mem_we     = 1'b1;  // [R15] [R18]
                nxt_r.addr = addr_inc(r_ff.addr);  // [R11] [R12]
                nxt_r.drv  = 1'b1;  // [R5]
              end
            end
          end
        end
        fram_link_pkg::PH_RDATA: begin
          if (r_ff.cnt == fram_link_pkg::BIT_ACK) begin
            if (!sda_i) begin
              // Master acknowledged: next sequential byte, no count limit.
              nxt_r.cnt   = fram_link_pkg::BIT_NONE;  // [R12]
              nxt_r.rd_sh = rd_data;  // [R13]
              nxt_r.drv   = ~rd_data[BW-1];  // [R13]
            end else begin
              nxt_r.state = fram_link_pkg::PH_IDLE;  // [R13] [R20]
              nxt_r.cnt   = fram_link_pkg::BIT_NONE;
              nxt_r.drv   = 1'b0;  // [R24]
            end
          end else begin
            nxt_r.cnt   = 4'(r_ff.cnt + 1'b1);
            nxt_r.rd_sh = {r_ff.rd_sh[BW-2:0], 1'b0};  // [R14]
            if (nxt_r.cnt == fram_link_pkg::BIT_ACK) begin
              nxt_r.addr = addr_inc(r_ff.addr);  // [R11]
              nxt_r.drv  = 1'b0;  // [R5]
            end else begin
              nxt_r.drv = ~nxt_r.rd_sh[BW-1];  // [R23]
            end
          end
        end
        default: begin
          nxt_r.state = fram_link_pkg::PH_IDLE;
          nxt_r.drv   = 1'b0;  // [R24]
        end
      endcase
    end
  end

  always_ff @(posedge scl or posedge s_ff.link_rst) begin
    if (s_ff.link_rst) begin
      r_ff <= '{state:      fram_link_pkg::PH_IDLE,
                cnt:        fram_link_pkg::BIT_NONE,
                sh:         fram_link_pkg::BYTE_RST,
                rd_sh:      fram_link_pkg::BYTE_RST,
                addr:       fram_link_pkg::ADDR_RST,
                page:       fram_link_pkg::PAGE_RST,
                dir_rd:     1'b0,
                refused:    1'b0,
                drv:        1'b0,
                start_seen: 1'b0,
                stop_seen:  1'b0,
                wp_meta:    1'b0,
                wp_sync:    1'b0};
    end else begin
      r_ff <= nxt_r;  // [R22]
    end
  end

  // The array has no reset; its content is whatever was last written.
  always_ff @(posedge scl) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;  // [R15]
    end
  end

  // Output changes only on the falling clock, so the line is steady while high.
  always_ff @(negedge scl or posedge s_ff.link_rst) begin
    if (s_ff.link_rst) begin
      fall_drv_ff <= 1'b0;
    end else begin
      fall_drv_ff <= r_ff.drv;  // [R23]
    end
  end

  // A STOP releases the line at once; no clock edge may follow it.
  assign sda_oe = fall_drv_ff & ~stop_pend;  // [R24] [R1]
  assign sda_o  = 1'b0;

endmodule : fram_link_slave

// ---- fram_link_slave_sva.sv ----
// Port checker for the two-wire memory slave.
`timescale 1ns/1ps
module fram_link_slave_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Link and status
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic wp,
  input wire logic link_busy
);
  logic oe_rise_ff;

  // The level seen at the rise must survive the whole high phase. The reset keeps
  // the first fall after power-up from comparing against an unknown level.
  always_ff @(posedge scl or posedge srst) begin
    if (srst) begin
      oe_rise_ff <= 1'b0;
    end else begin
      oe_rise_ff <= sda_oe;
    end
  end

  oe_reset_a: assert property (@(posedge clk) srst ##1 srst |-> !sda_oe)
    else $error("data driven during reset");
  busy_reset_a: assert property (@(posedge clk) srst ##1 srst ##1 srst |-> !link_busy)
    else $error("busy during reset");
  drain_low_a: assert property (@(posedge clk) disable iff (srst) sda_o == 1'b0)
    else $error("open drain level not low");
  oe_high_stable_a: assert property (@(negedge scl) disable iff (srst) sda_oe == oe_rise_ff)
    else $error("data drive changed while clock high");
  start_busy_a: assert property (@(posedge clk) disable iff (srst)
    scl && $past(scl) && $fell(sda_i) |-> ##[1:8] link_busy)
    else $error("start not taken");
  idle_release_a: assert property (@(posedge clk) disable iff (srst)
    !link_busy ##1 !link_busy |-> !sda_oe)
    else $error("data driven while idle");
  drive_busy_a: assert property (@(posedge scl) disable iff (srst) $rose(sda_oe) |-> link_busy)
    else $error("data driven outside a transfer");
endmodule : fram_link_slave_sva

bind fram_link_slave fram_link_slave_sva chk (.clk(clk), .srst(srst), .scl(scl), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .wp(wp), .link_busy(link_busy));

// ---- fram_link_master_model.sv ----
// Bus master model that makes the serial clock and drives the data wire.
`timescale 1ns/1ps
module fram_link_master_model (
  // Link
  output logic       scl,
  output logic       sda_low,
  input  wire logic  sda,
  // Observed bytes
  output logic       got,
  output logic [8:0] got_val
);
  localparam realtime Q = 31.25;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    got = 1'b0;
    got_val = 9'h000;
  end

  task automatic start();
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask : start

  // The clock is left standing high after a stop.
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask : stop

  task automatic bitx(input logic b, output logic r);
    #Q sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask : bitx

  task automatic xfer(input logic [7:0] d, input logic a);
    logic [8:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      v[i+1] = r;
    end
    bitx(a, r);
    v[0] = r;
    got_val = v;
    got = 1'b1;
    #1 got = 1'b0;
  endtask : xfer
endmodule : fram_link_master_model

// ---- i2c_fram_slave_access_tb.sv ----
// Self-checking bench for the two-wire memory slave.
`timescale 1ns/1ps
module i2c_fram_slave_access_tb;
  localparam logic [3:0] DEVT = 4'h6; // Arbitrary value.
  logic        clk;
  logic        srst;
  logic        wp;
  logic        scl;
  logic        sda_low;
  logic        sda;
  logic        sda_o;
  logic        sda_oe;
  logic        link_busy;
  logic        got;
  logic [8:0]  got_val;
  logic [7:0]  mem_ref [0:2047];
  logic [8:0]  exp_q [$];
  logic [10:0] a;
  logic        r;
  int          seed = 60982;
  int          num_errors = 0;
  int          checks_done = 0;

  // Pull-up wire; an unknown drive leaves it high instead of poisoning the input.
  assign sda = !(sda_low || (sda_oe === 1'b1 && sda_o === 1'b0));

  fram_link_slave #(.DEV_TYPE(DEVT)) DUT (.clk(clk), .srst(srst), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .wp(wp), .link_busy(link_busy));
  fram_link_master_model m (.scl(scl), .sda_low(sda_low), .sda(sda), .got(got), .got_val(got_val));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge got) check(got_val, exp_q.pop_front());

  task automatic xb(input logic [7:0] d, input logic k, input logic [8:0] e);
    exp_q.push_back(e);
    m.xfer(d, k);
  endtask : xb

  task automatic head(input logic [10:0] ad, input logic [3:0] t, input logic na);
    m.start();
    xb({t, ad[10:8], 1'b0}, 1'b1, {t, ad[10:8], 1'b0, na});
    if (!na) xb(ad[7:0], 1'b1, {ad[7:0], 1'b0});
  endtask : head

  task automatic wr(input logic [10:0] ad, input int n);
    logic [7:0] d;
    head(ad, DEVT, 1'b0);
    check({8'h00, link_busy}, 9'h001);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      xb(d, 1'b1, {d, wp});
      if (wp) break;
      mem_ref[ad] = d;
      ad++;
    end
    m.stop();
  endtask : wr

  task automatic rd(input logic [10:0] ad, input int n, input logic cur);
    if (!cur) head(ad, DEVT, 1'b0);
    m.start();
    xb({DEVT, ad[10:8], 1'b1}, 1'b1, {DEVT, ad[10:8], 2'b10});
    for (int i = 0; i < n; i++) begin
      xb(8'hFF, i == n - 1, {mem_ref[ad], i == n - 1});
      ad++;
    end
    m.stop();
  endtask : rd

  initial begin
    srst = 1'b1;
    wp = 1'b0;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    wr(11'h7FE, 3);
    rd(11'h7FE, 1, 1'b0);
    rd(11'h7FF, 2, 1'b1);
    head(11'h000, ~DEVT, 1'b1);
    m.stop();
    repeat (4) begin
      a = 11'($random(seed));
      wr(a, 4);
      rd(a, 4, 1'b0);
    end
    head(11'h7FE, DEVT, 1'b0);
    repeat (4) m.bitx(1'b0, r);
    m.stop();
    repeat (3) @(negedge clk);
    check({8'h00, link_busy}, 9'h000);
    head(11'h7FF, DEVT, 1'b0);
    repeat (5) m.bitx(1'b0, r);
    rd(11'h7FE, 2, 1'b0);
    @(negedge clk) wp = 1'b1;
    wr(11'h7FE, 2);
    @(negedge clk) wp = 1'b0;
    // A refused byte leaves the latch alone, so a current read starts where the write began.
    rd(11'h7FE, 1, 1'b1);
    rd(11'h7FE, 2, 1'b0);
    end_sim();
  end

  initial begin
    #400_000;
    num_errors++;
    end_sim();
  end
endmodule : i2c_fram_slave_access_tb
